/* core/fspc_defs.vh */
// constants for the flash self-program control block
`ifndef FSPC_DEFS_VH
`define FSPC_DEFS_VH

// =====================================================
// register offsets
`define FSPC_ADDR_W            4
`define FSPC_OFF_CTRL          4'h0
`define FSPC_OFF_DATA_LO       4'h1
`define FSPC_OFF_DATA_HI       4'h2
`define FSPC_OFF_PTR_LO        4'h3
`define FSPC_OFF_PTR_HI        4'h4
`define FSPC_OFF_LOCK          4'h5
`define FSPC_OFF_STATUS        4'h6
`define FSPC_OFF_BUF_WORD      4'h7
`define FSPC_OFF_BUF_LO        4'h8
`define FSPC_OFF_BUF_HI        4'h9

// =====================================================
// control bit positions
`define FSPC_B_IRQ_EN          7
`define FSPC_B_BUSY            6
`define FSPC_B_RSVD            5
`define FSPC_B_REEN            4
`define FSPC_B_LOCK            3
`define FSPC_B_PWRT            2
`define FSPC_B_PERS            1
`define FSPC_B_SEN             0
`define FSPC_CTRL_RESET        8'h00

// =====================================================
// accepted command patterns, lower five bits
`define FSPC_CMD_REEN          5'h11
`define FSPC_CMD_LOCK          5'h09
`define FSPC_CMD_PWRT          5'h05
`define FSPC_CMD_PERS          5'h03
`define FSPC_CMD_LOAD          5'h01

// =====================================================
// geometry and timing
`define FSPC_WORD_BITS         6
`define FSPC_PAGE_BITS         7
`define FSPC_PAGE_WORDS        64
`define FSPC_ARM_CYCLES        3'h4
`define FSPC_LPM_CYCLES        3'h3
`define FSPC_OP_TIME_NS        4000
`define FSPC_CLK_NS            5
`define FSPC_OP_CYCLES         ((`FSPC_OP_TIME_NS + `FSPC_CLK_NS - 1) / `FSPC_CLK_NS)
`define FSPC_BOOT_START        16'h1C00
`define FSPC_APP_START         16'h0000
`define FSPC_NO_CONCURRENT_SECTION_FIRST_PAGE   7'h70
`define FSPC_LOCK_RESET        8'hFF

`endif

/* core/fspc_top.v */
// flash self-program control: command register, arming window, page buffer, busy and halt
// Function
// - reset vector is zero when boot fuse is one, boot start when zero
// - program cannot change any fuse; fuse is an input only
// - ready interrupt requested while enable bits set and store enable clear
// - busy flag sets when erase or write to concurrent section starts
// - busy clears on re-enable after completion or on page load start
// - re-enable armed with store enable works only when no operation is running
// - re-enable written during page loading discards loaded buffer data
// - bit 5 of control reads zero
// - lock set with store enable programs lock bits from low data register
// - lock set clears on completion or arming window expiry
// - load within three cycles of lock arming returns lock or fuse bits
// - page write stores buffer into pointer-selected page
// - page write bit clears on completion or window expiry
// - core halted while erase or write targets the no-concurrent section
// - page erase erases pointer-selected page
// - page erase bit clears on completion or window expiry
// - store enable alone loads data pair into buffer word, bit zero ignored
// - store enable allows store for four cycles, clears on store or expiry
// - store enable stays set during erase or write as busy indicator
// - only the five listed command patterns take effect
// - target page latched at operation start
// - pointer splits into word-in-page and page index fields
// - buffer cleared after write, on re-enable, at reset; each word once
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
module fspc_top
(
    CLK_SYS,
    SRST,
    REG_ADDR,
    REG_WDATA,
    REG_WR,
    REG_RD,
    REG_RDATA,
    BOOT_RESET_SELECT_FUSE,
    FUSE_BITS_LO,
    GLOBAL_IRQ_EN,
    STORE_PROGRAM_INSTR,
    LOAD_PROGRAM_INSTR,
    RESET_VECTOR,
    STORE_READY_IRQ,
    CPU_HALT,
    SECTION_BUSY,
    LOAD_RESULT,
    LOAD_RESULT_VALID,
    FLASH_ERASE_STB,
    FLASH_WRITE_STB,
    FLASH_PAGE
);

`include "fspc_defs.vh"

input  wire                       CLK_SYS;
input  wire                       SRST;
input  wire [`FSPC_ADDR_W-1:0]    REG_ADDR;
input  wire [7:0]                 REG_WDATA;
input  wire                       REG_WR;
input  wire                       REG_RD;
output reg  [7:0]                 REG_RDATA;
input  wire                       BOOT_RESET_SELECT_FUSE;
input  wire [7:0]                 FUSE_BITS_LO;
input  wire                       GLOBAL_IRQ_EN;
input  wire                       STORE_PROGRAM_INSTR;
input  wire                       LOAD_PROGRAM_INSTR;
output reg  [15:0]                RESET_VECTOR;
output reg                        STORE_READY_IRQ;
output reg                        CPU_HALT;
output reg                        SECTION_BUSY;
output reg  [7:0]                 LOAD_RESULT;
output reg                        LOAD_RESULT_VALID;
output reg                        FLASH_ERASE_STB;
output reg                        FLASH_WRITE_STB;
output reg  [`FSPC_PAGE_BITS-1:0] FLASH_PAGE;

localparam [12:0] OP_CYC = `FSPC_OP_CYCLES;

// =====================================================
// operation states, one-hot
localparam [2:0] ST_IDLE  = 3'h1;
localparam [2:0] ST_ERASE = 3'h2;
localparam [2:0] ST_WRITE = 3'h4;

// =====================================================
// storage
reg [7:0]                  ctrl_ff;
reg [7:0]                  data_lo_ff;
reg [7:0]                  data_hi_ff;
reg [15:0]                 ptr_ff;
reg [7:0]                  lock_ff;
reg [2:0]                  arm_cnt_ff;
reg [2:0]                  lpm_cnt_ff;
reg [2:0]                  state_ff;
reg [12:0]                 op_cnt_ff;
reg                        no_concurrent_section_ff;
reg                        loading_ff;
reg [15:0]                 buf_mem [0:`FSPC_PAGE_WORDS-1];
reg [`FSPC_PAGE_WORDS-1:0] buf_used_ff;
reg [`FSPC_WORD_BITS-1:0]  rd_word_ff;

// =====================================================
// pointer field helpers
function [`FSPC_WORD_BITS-1:0] word_field;
    input [15:0] p;
    begin
        word_field = p[`FSPC_WORD_BITS:1];
    end
endfunction

function [`FSPC_PAGE_BITS-1:0] page_field;
    input [15:0] p;
    begin
        page_field = p[`FSPC_WORD_BITS+`FSPC_PAGE_BITS:`FSPC_WORD_BITS+1];
    end
endfunction

// erase or write command armed
function is_page_op;
    input [4:0] c;
    begin
        is_page_op = c[`FSPC_B_PERS] || c[`FSPC_B_PWRT];
    end
endfunction

// =====================================================
// command decode
wire        ctrl_wr   = REG_WR && (REG_ADDR == `FSPC_OFF_CTRL);
wire [4:0]  cmd       = REG_WDATA[4:0];
wire        op_run    = (state_ff != ST_IDLE);
wire        cmd_ok    = (cmd == `FSPC_CMD_REEN) || (cmd == `FSPC_CMD_LOCK) ||
                        (cmd == `FSPC_CMD_PWRT) || (cmd == `FSPC_CMD_PERS) ||
                        (cmd == `FSPC_CMD_LOAD);
wire        cmd_take  = ctrl_wr && cmd_ok && !op_run;
wire        armed     = ctrl_ff[`FSPC_B_SEN] && !op_run;
wire        store_go  = armed && STORE_PROGRAM_INSTR && !cmd_take;
wire        arm_exp   = armed && (arm_cnt_ff == 3'h1) && !store_go;
wire [`FSPC_WORD_BITS-1:0] wsel = word_field(ptr_ff);
wire [`FSPC_PAGE_BITS-1:0] psel = page_field(ptr_ff);
wire        in_no_concurrent_section   = (psel >= `FSPC_NO_CONCURRENT_SECTION_FIRST_PAGE);

// =====================================================
// control, arming and operation sequencing
always @(posedge CLK_SYS)
begin
    if (SRST)
    begin
        ctrl_ff         <= `FSPC_CTRL_RESET;
        arm_cnt_ff      <= 3'h0;
        lpm_cnt_ff      <= 3'h0;
        state_ff        <= ST_IDLE;
        op_cnt_ff       <= 13'h0000;
        no_concurrent_section_ff         <= 1'b0;
        loading_ff      <= 1'b0;
        lock_ff         <= `FSPC_LOCK_RESET;
        buf_used_ff     <= {`FSPC_PAGE_WORDS{1'b0}};
        FLASH_ERASE_STB <= 1'b0;
        FLASH_WRITE_STB <= 1'b0;
    end
    else
    begin
        FLASH_ERASE_STB <= 1'b0;
        FLASH_WRITE_STB <= 1'b0;
        if (lpm_cnt_ff != 3'h0)
            lpm_cnt_ff <= lpm_cnt_ff - 3'h1;
        if (ctrl_wr)
            ctrl_ff[`FSPC_B_IRQ_EN] <= REG_WDATA[`FSPC_B_IRQ_EN];
        if (cmd_take)
        begin
            ctrl_ff[4:0] <= cmd;
            arm_cnt_ff   <= `FSPC_ARM_CYCLES;
            lpm_cnt_ff   <= (cmd == `FSPC_CMD_LOCK) ? `FSPC_LPM_CYCLES : 3'h0;
            if (cmd == `FSPC_CMD_REEN && loading_ff)
            begin
                buf_used_ff <= {`FSPC_PAGE_WORDS{1'b0}};
                loading_ff  <= 1'b0;
            end
        end
        else if (arm_exp)
        begin
            ctrl_ff[4:0] <= 5'h00;
            arm_cnt_ff   <= 3'h0;
        end
        else if (store_go)
        begin
            arm_cnt_ff <= 3'h0;
            if (is_page_op(ctrl_ff[4:0]))
            begin
                no_concurrent_section_ff   <= in_no_concurrent_section;
                op_cnt_ff <= OP_CYC;
                state_ff  <= ctrl_ff[`FSPC_B_PERS] ? ST_ERASE : ST_WRITE;
                if (!in_no_concurrent_section)
                    ctrl_ff[`FSPC_B_BUSY] <= 1'b1;
                FLASH_ERASE_STB <= ctrl_ff[`FSPC_B_PERS];
                FLASH_WRITE_STB <= ctrl_ff[`FSPC_B_PWRT];
            end
            else if (ctrl_ff[`FSPC_B_LOCK])
            begin
                lock_ff      <= lock_ff & data_lo_ff;
                ctrl_ff[4:0] <= 5'h00;
            end
            else if (ctrl_ff[`FSPC_B_REEN])
            begin
                ctrl_ff[`FSPC_B_BUSY] <= 1'b0;
                buf_used_ff  <= {`FSPC_PAGE_WORDS{1'b0}};
                loading_ff   <= 1'b0;
                ctrl_ff[4:0] <= 5'h00;
            end
            else
            begin
                ctrl_ff[`FSPC_B_BUSY] <= 1'b0;
                loading_ff   <= 1'b1;
                if (!buf_used_ff[wsel])
                    buf_used_ff[wsel] <= 1'b1;
                ctrl_ff[4:0] <= 5'h00;
            end
        end
        else if (armed && arm_cnt_ff != 3'h0)
            arm_cnt_ff <= arm_cnt_ff - 3'h1;
        if (op_run)
        begin
            if (op_cnt_ff == 13'h0001)
            begin
                state_ff     <= ST_IDLE;
                ctrl_ff[4:0] <= 5'h00;
                if (state_ff == ST_WRITE)
                begin
                    buf_used_ff <= {`FSPC_PAGE_WORDS{1'b0}};
                    loading_ff  <= 1'b0;
                end
            end
            op_cnt_ff <= op_cnt_ff - 13'h0001;
        end
    end
end

// =====================================================
// page buffer storage, no reset needed; valid bits gate it
always @(posedge CLK_SYS)
begin
    if (store_go && ctrl_ff[4:0] == `FSPC_CMD_LOAD && !buf_used_ff[wsel])
        buf_mem[wsel] <= {data_hi_ff, data_lo_ff};
end

// =====================================================
// data and pointer registers
always @(posedge CLK_SYS)
begin
    if (SRST)
    begin
        data_lo_ff <= 8'h00;
        data_hi_ff <= 8'h00;
        ptr_ff     <= 16'h0000;
        rd_word_ff <= {`FSPC_WORD_BITS{1'b0}};
    end
    else if (REG_WR)
    begin
        case (REG_ADDR)
            `FSPC_OFF_DATA_LO:  data_lo_ff       <= REG_WDATA;
            `FSPC_OFF_DATA_HI:  data_hi_ff       <= REG_WDATA;
            `FSPC_OFF_PTR_LO:   ptr_ff[7:0]      <= REG_WDATA;
            `FSPC_OFF_PTR_HI:   ptr_ff[15:8]     <= REG_WDATA;
            `FSPC_OFF_BUF_WORD: rd_word_ff       <= REG_WDATA[`FSPC_WORD_BITS-1:0];
            default:            rd_word_ff       <= rd_word_ff;
        endcase
    end
end

// =====================================================
// register read port, data one cycle after strobe
reg [7:0] nxt_rdata;
wire [15:0] buf_rd = buf_used_ff[rd_word_ff] ? buf_mem[rd_word_ff] : 16'hFFFF;
always @*
begin
    nxt_rdata = 8'h00;
    case (REG_ADDR)
        `FSPC_OFF_CTRL:     nxt_rdata = {ctrl_ff[7:6], 1'b0, ctrl_ff[4:0]};
        `FSPC_OFF_DATA_LO:  nxt_rdata = data_lo_ff;
        `FSPC_OFF_DATA_HI:  nxt_rdata = data_hi_ff;
        `FSPC_OFF_PTR_LO:   nxt_rdata = ptr_ff[7:0];
        `FSPC_OFF_PTR_HI:   nxt_rdata = ptr_ff[15:8];
        `FSPC_OFF_LOCK:     nxt_rdata = lock_ff;
        `FSPC_OFF_STATUS:   nxt_rdata = {5'h00, no_concurrent_section_ff && op_run, loading_ff, op_run};
        `FSPC_OFF_BUF_WORD: nxt_rdata = {2'h0, rd_word_ff};
        `FSPC_OFF_BUF_LO:   nxt_rdata = buf_rd[7:0];
        `FSPC_OFF_BUF_HI:   nxt_rdata = buf_rd[15:8];
        default:            nxt_rdata = 8'h00;
    endcase
end

// =====================================================
// registered outputs
always @(posedge CLK_SYS)
begin
    if (SRST)
    begin
        REG_RDATA         <= 8'h00;
        RESET_VECTOR      <= `FSPC_APP_START;
        STORE_READY_IRQ   <= 1'b0;
        CPU_HALT          <= 1'b0;
        SECTION_BUSY      <= 1'b0;
        LOAD_RESULT       <= 8'h00;
        LOAD_RESULT_VALID <= 1'b0;
        FLASH_PAGE        <= {`FSPC_PAGE_BITS{1'b0}};
    end
    else
    begin
        REG_RDATA <= REG_RD ? nxt_rdata : 8'h00;
        // fuse is read only; no write path reaches it
        RESET_VECTOR <= BOOT_RESET_SELECT_FUSE ? `FSPC_APP_START : `FSPC_BOOT_START;
        STORE_READY_IRQ <= ctrl_ff[`FSPC_B_IRQ_EN] && GLOBAL_IRQ_EN &&
                           !ctrl_ff[`FSPC_B_SEN];
        CPU_HALT     <= op_run ? no_concurrent_section_ff : (store_go && is_page_op(ctrl_ff[4:0]) && in_no_concurrent_section);
        if (op_run && op_cnt_ff == 13'h0001)
            CPU_HALT <= 1'b0;
        SECTION_BUSY <= ctrl_ff[`FSPC_B_BUSY];
        LOAD_RESULT_VALID <= LOAD_PROGRAM_INSTR && (lpm_cnt_ff != 3'h0);
        if (LOAD_PROGRAM_INSTR && lpm_cnt_ff != 3'h0)
            LOAD_RESULT <= ptr_ff[0] ? FUSE_BITS_LO : lock_ff;
        if (store_go)
            FLASH_PAGE <= psel;
    end
end

endmodule

/* verif/fspc_top_props.sv */
// property checker on the flash self-program control ports
module fspc_props
(
    input wire        CLK_SYS,
    input wire        SRST,
    input wire        BOOT_RESET_SELECT_FUSE,
    input wire        GLOBAL_IRQ_EN,
    input wire        STORE_PROGRAM_INSTR,
    input wire        LOAD_PROGRAM_INSTR,
    input wire [15:0] RESET_VECTOR,
    input wire        STORE_READY_IRQ,
    input wire        CPU_HALT,
    input wire        LOAD_RESULT_VALID,
    input wire        FLASH_ERASE_STB,
    input wire        FLASH_WRITE_STB,
    input wire [6:0]  FLASH_PAGE
);
timeunit 1ns;
timeprecision 1ps;
// ==========================================
// assertions
default clocking cb @(posedge CLK_SYS);
endclocking
default disable iff (SRST);
wire op_stb = FLASH_ERASE_STB || FLASH_WRITE_STB;
vector_select_a:
    assert property (!SRST |=> RESET_VECTOR == ($past(BOOT_RESET_SELECT_FUSE) ? 16'h0000 : 16'h1C00))
    else $error("reset vector wrong");
irq_gate_a:
    assert property (STORE_READY_IRQ |-> $past(GLOBAL_IRQ_EN)) else $error("irq without global enable");
irq_quiet_a:
    assert property (op_stb |-> !STORE_READY_IRQ [*8]) else $error("irq during operation");
store_cause_a:
    assert property (op_stb |-> $past(STORE_PROGRAM_INSTR)) else $error("operation without store");
strobe_pulse_a:
    assert property (op_stb |=> !op_stb) else $error("strobe longer than one cycle");
page_hold_a:
    assert property (op_stb |=> $stable(FLASH_PAGE) [*8]) else $error("page not latched");
halt_no_concurrent_section_a:
    assert property (op_stb && FLASH_PAGE >= 7'h70 |=> CPU_HALT [*8]) else $error("core not halted");
halt_len_a:
    assert property ($fell(CPU_HALT) |-> $past(CPU_HALT, 700)) else $error("halt too short");
load_pulse_a:
    assert property (LOAD_RESULT_VALID |-> $past(LOAD_PROGRAM_INSTR) ##1 !LOAD_RESULT_VALID)
    else $error("load answer wrong");
endmodule

/* verif/fspc_core_model.sv */
// processor core model issuing store and load instructions
module fspc_core_model
(
    input wire   clk,
    input wire   halt,
    output logic store_pulse,
    output logic load_pulse
);
timeunit 1ns;
timeprecision 1ps;
initial
begin
    store_pulse = 1'b0;
    load_pulse  = 1'b0;
end
// one instruction after gap cycles; a halted core issues nothing
task run(input bit is_load, input int gap);
    repeat (gap) @(posedge clk);
    while (halt === 1'b1) @(posedge clk);
    if (is_load)
        load_pulse <= 1'b1;
    else
        store_pulse <= 1'b1;
    @(posedge clk);
    load_pulse  <= 1'b0;
    store_pulse <= 1'b0;
endtask
endmodule

/* verif/fspc_top_test.sv */
// self-checking bench for the flash self-program control block
module fspc_top_test;
timeunit 1ns;
timeprecision 1ps;
logic        CLK_SYS, SRST, REG_WR, REG_RD, BOOT_RESET_SELECT_FUSE, GLOBAL_IRQ_EN;
logic [3:0]  REG_ADDR;
logic [7:0]  REG_WDATA, REG_RDATA, FUSE_BITS_LO, LOAD_RESULT, v;
logic [15:0] RESET_VECTOR;
logic [6:0]  FLASH_PAGE;
logic        STORE_PROGRAM_INSTR, LOAD_PROGRAM_INSTR, STORE_READY_IRQ, CPU_HALT;
logic        SECTION_BUSY, LOAD_RESULT_VALID, FLASH_ERASE_STB, FLASH_WRITE_STB;
int          error_cnt, n_compared, i;
logic [7:0]  bad [5] = '{8'h87, 8'h93, 8'h82, 8'h90, 8'h9F};
// ==========================================
// design and core model
fspc_top dut (.CLK_SYS, .SRST, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .BOOT_RESET_SELECT_FUSE,
    .FUSE_BITS_LO, .GLOBAL_IRQ_EN, .STORE_PROGRAM_INSTR, .LOAD_PROGRAM_INSTR, .RESET_VECTOR, .STORE_READY_IRQ,
    .CPU_HALT, .SECTION_BUSY, .LOAD_RESULT, .LOAD_RESULT_VALID, .FLASH_ERASE_STB, .FLASH_WRITE_STB, .FLASH_PAGE);
fspc_core_model core (.clk(CLK_SYS), .halt(CPU_HALT), .store_pulse(STORE_PROGRAM_INSTR),
    .load_pulse(LOAD_PROGRAM_INSTR));
initial
begin
    CLK_SYS = 1'b0;
    forever #2.5 CLK_SYS = ~CLK_SYS;
end
// ==========================================
// access tasks
task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
        error_cnt++;
        $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
endtask
task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CLK_SYS);
    REG_WR    <= 1'b1;
    REG_ADDR  <= a;
    REG_WDATA <= d;
    @(posedge CLK_SYS);
    REG_WR    <= 1'b0;
endtask
task rd(input logic [3:0] a);
    @(posedge CLK_SYS);
    REG_RD   <= 1'b1;
    REG_ADDR <= a;
    @(posedge CLK_SYS);
    REG_RD   <= 1'b0;
    #1 v = REG_RDATA;
endtask
task rc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    rd(a);
    chk(v & m, e);
endtask
task wd(input logic [5:0] w, input logic [15:0] e);
    wr(4'h7, {2'b00, w});
    rc(4'h8, 8'hFF, e[7:0]);
    rc(4'h9, 8'hFF, e[15:8]);
endtask
task ld(input logic [5:0] w, input logic [15:0] d);
    wr(4'h1, d[7:0]);
    wr(4'h2, d[15:8]);
    wr(4'h3, {1'b0, w, 1'b1});
    wr(4'h4, 8'h00);
    wr(4'h0, 8'h81);
    core.run(1'b0, 1);
endtask
task test_done;
    if (error_cnt == 0 && n_compared > 0)
        $display("Simulation passed");
    else
        $display("Simulation failed");
    $finish;
endtask
initial
begin
    repeat (20000) @(posedge CLK_SYS);
    error_cnt++;
    test_done();
end
// ==========================================
// scenarios
initial
begin
    {SRST, REG_WR, REG_RD, BOOT_RESET_SELECT_FUSE, GLOBAL_IRQ_EN} = 5'b10010;
    REG_ADDR     = 4'h0;
    REG_WDATA    = 8'h00;
    FUSE_BITS_LO = 8'h5A;
    repeat (3) @(posedge CLK_SYS);
    SRST <= 1'b0;
    repeat (2) @(posedge CLK_SYS);
    #1 chk(RESET_VECTOR, 16'h0000);
    rc(4'h0, 8'hFF, 8'h00);
    rc(4'h5, 8'hFF, 8'hFF);
    @(posedge CLK_SYS);
    BOOT_RESET_SELECT_FUSE <= 1'b0;
    GLOBAL_IRQ_EN          <= 1'b1;
    repeat (2) @(posedge CLK_SYS);
    #1 chk(RESET_VECTOR, 16'h1C00);
    wr(4'h0, 8'hA0);
    rc(4'h0, 8'hFF, 8'h80);
    chk(STORE_READY_IRQ, 1'b1);
    @(posedge CLK_SYS);
    GLOBAL_IRQ_EN <= 1'b0;
    repeat (2) @(posedge CLK_SYS);
    #1 chk(STORE_READY_IRQ, 1'b0);
    @(posedge CLK_SYS);
    GLOBAL_IRQ_EN <= 1'b1;
    for (i = 0; i < 5; i++)
    begin
        wr(4'h0, bad[i]);
        rc(4'h0, 8'hFF, 8'h80);
    end
    ld(6'd5, 16'h1234);
    rc(4'h0, 8'hFF, 8'h80);
    wd(6'd5, 16'h1234);
    ld(6'd5, 16'hABCD);
    wd(6'd5, 16'h1234);
    wr(4'h3, 8'h0C);
    wr(4'h0, 8'h81);
    core.run(1'b0, 6);
    wd(6'd6, 16'hFFFF);
    wr(4'h0, 8'h89);
    repeat (4) @(posedge CLK_SYS);
    rc(4'h0, 8'hFF, 8'h80);
    wr(4'h3, 8'h01);
    wr(4'h0, 8'h89);
    core.run(1'b1, 1);
    #1 chk({LOAD_RESULT_VALID, LOAD_RESULT}, {1'b1, 8'h5A});
    wr(4'h3, 8'h00);
    wr(4'h0, 8'h89);
    core.run(1'b1, 1);
    #1 chk({LOAD_RESULT_VALID, LOAD_RESULT}, {1'b1, 8'hFF});
    wr(4'h1, 8'hFC);
    wr(4'h0, 8'h89);
    core.run(1'b0, 1);
    rc(4'h5, 8'hFF, 8'hFC);
    rc(4'h0, 8'hFF, 8'h80);
    wr(4'h3, 8'h80);
    wr(4'h4, 8'h01);
    wr(4'h0, 8'h83);
    core.run(1'b0, 1);
    #1 chk({FLASH_ERASE_STB, FLASH_PAGE}, {1'b1, 7'h03});
    wr(4'h4, 8'h05);
    rc(4'h0, 8'h41, 8'h41);
    chk(SECTION_BUSY, 1'b1);
    rc(4'h6, 8'hFF, 8'h03);
    chk(STORE_READY_IRQ, 1'b0);
    wr(4'h0, 8'h91);
    for (i = 0; i < 600 && v[0] !== 1'b0; i++)
        rd(4'h0);
    rc(4'h0, 8'h5F, 8'h40);
    chk(FLASH_PAGE, 7'h03);
    wr(4'h0, 8'h91);
    core.run(1'b0, 1);
    rc(4'h0, 8'hFF, 8'h80);
    ld(6'd9, 16'h00AA);
    wr(4'h3, 8'h00);
    wr(4'h4, 8'h38);
    wr(4'h0, 8'h85);
    core.run(1'b0, 1);
    #1 chk({FLASH_WRITE_STB, FLASH_PAGE}, {1'b1, 7'h70});
    @(posedge CLK_SYS);
    #1 chk({CPU_HALT, SECTION_BUSY}, 2'b10);
    for (i = 0; i < 1000 && CPU_HALT === 1'b1; i++)
        @(posedge CLK_SYS);
    rc(4'h0, 8'hFF, 8'h80);
    wd(6'd9, 16'hFFFF);
    ld(6'd2, 16'h5555);
    wr(4'h0, 8'h91);
    repeat (5) @(posedge CLK_SYS);
    wd(6'd2, 16'hFFFF);
    ld(6'd3, 16'h1111);
    SRST <= 1'b1;
    repeat (3) @(posedge CLK_SYS);
    SRST <= 1'b0;
    wd(6'd3, 16'hFFFF);
    chk(RESET_VECTOR, 16'h1C00);
    test_done();
end
endmodule
bind fspc_top fspc_props chk_i (.CLK_SYS, .SRST, .BOOT_RESET_SELECT_FUSE, .GLOBAL_IRQ_EN, .STORE_PROGRAM_INSTR,
    .LOAD_PROGRAM_INSTR, .RESET_VECTOR, .STORE_READY_IRQ, .CPU_HALT, .LOAD_RESULT_VALID, .FLASH_ERASE_STB,
    .FLASH_WRITE_STB, .FLASH_PAGE);
